// ---- sim/serial_sender.sv ----
`timescale 1ns/1ps
module serial_sender (
	input wire logic mclk_i,
	output logic line_o
);
	initial line_o = 1'b1;
	// start, nb data bits lsb first, stop
	task automatic send(input logic [8:0] b, input int bitc,
			input int nb = 8);
		@(posedge mclk_i);
		line_o <= 1'b0;
		repeat (bitc) @(posedge mclk_i);
		for (int i = 0; i < nb; i++) begin
			line_o <= b[i];
			repeat (bitc) @(posedge mclk_i);
		end
		line_o <= 1'b1;
		repeat (bitc) @(posedge mclk_i);
	endtask
	task automatic send_break(input int n);
		@(posedge mclk_i);
		line_o <= 1'b0;
		repeat (n) @(posedge mclk_i);
		line_o <= 1'b1;
		repeat (n / 4) @(posedge mclk_i);
	endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb
	import uart_pkg::*;
;
	logic mclk_i, rstn_i, psel, penable, pwrite, pready, pslverr, rx, tx;
	logic err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	int mismatches, n_checks;
	int dv[4] = '{512, 128, 128, 32};
	serial_sender u_serial_sender (.mclk_i(mclk_i), .line_o(rx));
	uart_async_autobaud u_uart_async_autobaud (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .serial_input_pin_i(rx),
		.serial_output_pin_o(tx));
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do @(posedge mclk_i); while (pready !== 1'b1);
		rd_q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
			input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd_q & m);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rdc("rate_ctl rst", OFS_RATE_CONTROL, 32'hFFFFFFBF, 32'h0);
		rdc("div_lo rst", OFS_DIVIDER_LOW_BYTE, 32'hFFFFFFFF, 32'h0);
		rdc("div_hi rst", OFS_DIVIDER_HIGH_BYTE, 32'hFFFFFFFF, 32'h0);
		rdc("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, OFS_RATE_CONTROL, 32'h80);
		rdc("ovf set", OFS_RATE_CONTROL, 32'h80, 32'h80);
		apb(1'b1, OFS_RATE_CONTROL, 32'h0);
		rdc("ovf clr", OFS_RATE_CONTROL, 32'h80, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_rx(input logic nine);
		apb(1'b1, OFS_TRANSMIT_CONTROL, 32'h24);
		apb(1'b1, OFS_RATE_CONTROL, 32'h08);
		apb(1'b1, OFS_DIVIDER_LOW_BYTE, 32'h09);
		apb(1'b1, OFS_DIVIDER_HIGH_BYTE, 32'h00);
		apb(1'b1, OFS_RECEIVE_CONTROL, {24'h0, 1'b1, nine, 6'h10});
		u_serial_sender.send({1'b1, 8'hA3}, 40, 8 + nine);
		rdc("rx flag", OFS_FLAGS, 32'h1, 32'h1);
		rdc("rx ninth", OFS_RECEIVE_CONTROL, 32'h1, {31'h0, nine});
		rdc("rx data", OFS_RECEIVE_BUFFER, 32'hFF, 32'hA3);
		rdc("rx flag clr", OFS_FLAGS, 32'h1, 32'h0);
		$display("test rx done");
	endtask
	task automatic t_tx(input logic nine);
		logic [8:0] b;
		int k;
		b = {nine, 8'h5A};
		k = 0;
		apb(1'b1, OFS_TRANSMIT_CONTROL, {24'h0, 1'b0, nine, 5'h12, nine});
		apb(1'b1, OFS_TRANSMIT_BUFFER, {24'h0, b[7:0]});
		while (tx !== 1'b0 && k < 400) begin
			@(negedge mclk_i);
			k++;
		end
		repeat (20) @(negedge mclk_i);
		chk("tx start", 32'h0, {31'h0, tx});
		for (int i = 0; i < 8 + nine; i++) begin
			repeat (40) @(negedge mclk_i);
			chk("tx bit", {31'h0, b[i]}, {31'h0, tx});
		end
		repeat (40) @(negedge mclk_i);
		chk("tx stop", 32'h1, {31'h0, tx});
		$display("test tx done");
	endtask
	task automatic t_detect(input logic wide, input logic high,
			input logic wake, input int d);
		int bitc;
		bitc = d * 5 / 8;
		apb(1'b1, OFS_TRANSMIT_CONTROL, {29'h0, high, 2'h0});
		apb(1'b1, OFS_RATE_CONTROL, {28'h0, wide, 1'b0, wake, 1'b1});
		rdc("count clr", OFS_DIVIDER_LOW_BYTE, 32'hFF, 32'h0);
		if (wake)
			u_serial_sender.send_break(bitc * 12);
		u_serial_sender.send(8'h55, bitc);
		rdc("auto clr", OFS_RATE_CONTROL, 32'h1, 32'h0);
		apb(1'b0, OFS_DIVIDER_LOW_BYTE, 32'h0);
		n_checks++;
		if ((rd_q >= 32'd4 && rd_q <= 32'd6) !== 1'b1) begin
			mismatches++;
			$display("mismatch count expected 5 seen %h", rd_q);
		end
		rdc("high zero", OFS_DIVIDER_HIGH_BYTE, 32'hFF, 32'h0);
		rdc("det flag", OFS_FLAGS, 32'h1, 32'h1);
		apb(1'b0, OFS_RECEIVE_BUFFER, 32'h0);
		rdc("det flag clr", OFS_FLAGS, 32'h1, 32'h0);
		$display("test detect done");
	endtask
	task automatic t_sync();
		apb(1'b1, OFS_TRANSMIT_CONTROL, 32'h10);
		apb(1'b1, OFS_RATE_CONTROL, 32'h09);
		u_serial_sender.send(8'h55, 20);
		rdc("no detect", OFS_FLAGS, 32'h1, 32'h0);
		apb(1'b1, OFS_RATE_CONTROL, 32'h0);
		apb(1'b1, OFS_TRANSMIT_CONTROL, 32'h0);
		$display("test sync done");
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		rstn_i = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		n_checks = 0;
		repeat (5) @(posedge mclk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_rx(1'b0);
		t_rx(1'b1);
		t_tx(1'b0);
		t_tx(1'b1);
		for (int m = 0; m < 4; m++)
			t_detect(m[1], m[0], 1'b0, dv[m]);
		t_detect(1'b1, 1'b1, 1'b1, 32);
		t_sync();
		stop_test();
	end
	initial begin
		repeat (40000) @(posedge mclk_i);
		mismatches++;
		stop_test();
	end
endmodule

// ---- sim/uart_async_autobaud_monitor.sv ----
`timescale 1ns/1ps
module uart_async_autobaud_monitor
	import uart_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic serial_input_pin_i,
	input wire logic serial_output_pin_o
);
	wire acc = psel_i & penable_i;
	wire rd = acc & ~pwrite_i;
	wire wr = acc & pwrite_i;
	wire mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= OFS_FLAGS);
	wire rate_w = wr && (paddr_i == OFS_RATE_CONTROL);
	logic ovf_r, tx_r, wide_r, hi_r;
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			ovf_r <= 1'b0;
			tx_r <= 1'b0;
			wide_r <= 1'b0;
			hi_r <= 1'b0;
		end else begin
			if (rate_w)
				ovf_r <= pwdata_i[BC_OVERFLOW];
			wide_r <= wide_r | (rate_w & pwdata_i[BC_WIDE_DIVIDER]);
			tx_r <= tx_r | (wr && paddr_i == OFS_TRANSMIT_CONTROL
				&& pwdata_i[TC_TX_ENABLE]);
			hi_r <= hi_r | (wr && paddr_i == OFS_DIVIDER_HIGH_BYTE);
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	ready_high_a: assert property (acc |-> pready_o)
		else $error("pready low in access");
	bad_addr_a: assert property (rd && !mapped |-> pslverr_o && prdata_o == 0)
		else $error("unmapped read not refused");
	good_addr_a: assert property (acc && mapped |-> !pslverr_o)
		else $error("error on mapped address");
	upper_zero_a: assert property (rd |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	txbuf_read_a: assert property (rd && paddr_i == OFS_TRANSMIT_BUFFER
		|-> prdata_o == 32'h0) else $error("transmit buffer readable");
	overflow_sw_a: assert property (
		rd && paddr_i == OFS_RATE_CONTROL && ovf_r |-> prdata_o[BC_OVERFLOW])
		else $error("overflow bit lost software set");
	tx_idle_a: assert property (!tx_r |-> serial_output_pin_o)
		else $error("transmit line not idle");
	high_byte_a: assert property (
		rd && paddr_i == OFS_DIVIDER_HIGH_BYTE && !wide_r && !hi_r
		|-> prdata_o[7:0] == 8'h00) else $error("high byte moved");
	reset_clear_a: assert property (disable iff (1'b0)
		!rstn_i |=> prdata_o == 32'h0) else $error("read data not reset");
	cover property (rd && paddr_i == OFS_RATE_CONTROL && ovf_r);
	cover property (rd && !mapped);
	cover property ($fell(serial_output_pin_o));
endmodule

bind uart_async_autobaud uart_async_autobaud_monitor u_mon (
	.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .serial_input_pin_i(serial_input_pin_i),
	.serial_output_pin_o(serial_output_pin_o));

// ---- src/rate_gen.sv ----
`timescale 1ns/1ps
module rate_gen
	import uart_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	rate_if.gen rif
);

	// ------------------------------------------------------------
	// divider and counters
	// ------------------------------------------------------------
	logic [15:0] div_r;
	logic [8:0] rx_pre_r;
	logic [8:0] tx_pre_r;
	logic [8:0] det_pre_r;
	logic [15:0] rx_cnt_r;
	logic [15:0] tx_cnt_r;

	wire [8:0] pre_lim = prescale_limit(rif.wide, rif.high, 1'b0);
	wire [8:0] det_lim = prescale_limit(rif.wide, rif.high, 1'b1);
	// only the low byte counts in the narrow modes
	wire [15:0] cnt_lim = rif.wide ? div_r : {8'h00, div_r[7:0]};
	wire rx_pre_end = rx_pre_r >= pre_lim;
	wire tx_pre_end = tx_pre_r >= pre_lim;
	wire det_pre_end = det_pre_r >= det_lim;
	wire rx_end = rx_pre_end && (rx_cnt_r >= cnt_lim);
	wire tx_end = tx_pre_end && (tx_cnt_r >= cnt_lim);

	assign rif.divider = div_r;
	assign rif.rx_tick = rx_end && !rif.det_run;
	assign rif.tx_tick = tx_end && !rif.det_run;
	assign rif.det_wrap = rif.det_run && det_pre_end && (div_r == COUNT_MAX);

	function automatic logic [15:0] cnt_step(input logic [15:0] c,
			input logic pe, input logic e);
		cnt_step = e ? 16'h0000 : (pe ? 16'(c + 16'h0001) : c);
	endfunction

	// ------------------------------------------------------------
	// bit timing, one phase per direction
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rx_pre_r <= 9'h000;
			rx_cnt_r <= 16'h0000;
			tx_pre_r <= 9'h000;
			tx_cnt_r <= 16'h0000;
		end else begin
			tx_pre_r <= tx_pre_end ? 9'h000 : 9'(tx_pre_r + 9'h001);
			tx_cnt_r <= cnt_step(tx_cnt_r, tx_pre_end, tx_end);
			if (rif.rx_restart) begin
				// start half a bit in so samples fall mid-bit
				rx_pre_r <= 9'h000;
				rx_cnt_r <= {1'b0, cnt_lim[15:1]};
			end else begin
				rx_pre_r <= rx_pre_end ? 9'h000 : 9'(rx_pre_r + 9'h001);
				rx_cnt_r <= cnt_step(rx_cnt_r, rx_pre_end, rx_end);
			end
		end
	end

	// ------------------------------------------------------------
	// divider register, doubling as the detection counter
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			div_r <= RST_DIVIDER;
			det_pre_r <= 9'h000;
		end else if (rif.det_clear) begin
			div_r <= RST_DIVIDER;
			det_pre_r <= 9'h000;
		end else if (rif.det_run) begin
			det_pre_r <= det_pre_end ? 9'h000 : 9'(det_pre_r + 9'h001);
			if (det_pre_end) begin
				div_r <= 16'(div_r + 16'h0001);
			end
		end else begin
			if (rif.wr_low) begin
				div_r[7:0] <= rif.wdata;
			end
			if (rif.wr_high) begin
				div_r[15:8] <= rif.wdata;
			end
		end
	end

endmodule

// ---- src/rate_if.sv ----
`timescale 1ns/1ps
interface rate_if;
	logic wide;
	logic high;
	logic wr_low;
	logic wr_high;
	logic [7:0] wdata;
	logic rx_restart;
	logic det_clear;
	logic det_run;
	logic [15:0] divider;
	logic rx_tick;
	logic tx_tick;
	logic det_wrap;

	modport gen(input wide, high, wr_low, wr_high, wdata, rx_restart,
		det_clear, det_run, output divider, rx_tick, tx_tick, det_wrap);
	modport ctl(output wide, high, wr_low, wr_high, wdata, rx_restart,
		det_clear, det_run, input divider, rx_tick, tx_tick, det_wrap);
endinterface

// ---- src/uart_async_autobaud.sv ----
// Function
// - detection only in async mode, with wake set or clear
// - enable clears counter, waits for start
// - count from first rise to fifth
// - fifth rising edge clears auto-rate enable
// - counter rollover sets overflow bit seven
// - rollover keeps detection running and enabled
// - detection clock is one eighth rate
// - high byte counts in every mode, used only when wide
// - receiver held idle during detection
// - fifth edge sets receive flag
// - with wake, detect character after break
// - clocked-mode bit clear selects async mode
// - start, eight or nine data, stop
// - lsb first, shared rate, nine-bit chosen per direction
// - prescale per high-rate and wide bits
// - no hardware parity, ninth bit free
// - wide plus high: divider 207 9.615k
// - wide only: divider 207 2.403k
`timescale 1ns/1ps
module uart_async_autobaud
	import uart_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic serial_input_pin_i,
	output logic serial_output_pin_o
);

	typedef enum logic [2:0] {
		AB_OFF, AB_BREAK_LOW, AB_BREAK_HIGH, AB_START, AB_FIRST, AB_COUNT
	} detect_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

	rate_if rif();

	rate_gen u_rate_gen (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.rif(rif)
	);

	// ------------------------------------------------------------
	// pin synchroniser and edges
	// ------------------------------------------------------------
	logic rx_meta_r;
	logic rx_sync_r;
	logic rx_prev_r;

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
			rx_prev_r <= 1'b1;
		end else begin
			rx_meta_r <= serial_input_pin_i;
			rx_sync_r <= rx_meta_r;
			rx_prev_r <= rx_sync_r;
		end
	end

	wire rx_fall = rx_prev_r && !rx_sync_r;
	wire rx_rise = !rx_prev_r && rx_sync_r;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic [7:0] tctl_r;
	logic [7:0] rctl_r;
	logic wide_r;
	logic wake_r;
	logic auto_rate_enable_r;
	logic rate_count_overflow_r;
	logic [8:0] txbuf_r;
	logic txbuf_full_r;
	logic [7:0] rxbuf_r;
	logic rx_ninth_r;
	logic receive_flag_r;
	logic framing_r;
	logic overrun_r;
	logic [31:0] rdata_r;
	logic shifter_busy_r;
	detect_state_e ab_r;
	rx_state_e rxs_r;

	wire access = psel_i && penable_i;
	wire wr = access && pwrite_i;
	wire rd = access && !pwrite_i;
	wire hit_tc = paddr_i == OFS_TRANSMIT_CONTROL;
	wire hit_rc = paddr_i == OFS_RECEIVE_CONTROL;
	wire hit_bc = paddr_i == OFS_RATE_CONTROL;
	wire hit_lo = paddr_i == OFS_DIVIDER_LOW_BYTE;
	wire hit_hi = paddr_i == OFS_DIVIDER_HIGH_BYTE;
	wire hit_tb = paddr_i == OFS_TRANSMIT_BUFFER;
	wire hit_rb = paddr_i == OFS_RECEIVE_BUFFER;
	wire hit_fl = paddr_i == OFS_FLAGS;
	wire mapped = hit_tc | hit_rc | hit_bc | hit_lo | hit_hi | hit_tb |
		hit_rb | hit_fl;

	assign pready_o = 1'b1;
	assign pslverr_o = access && !mapped;
	assign prdata_o = rdata_r;

	wire async_mode = !tctl_r[TC_CLOCKED_MODE];
	wire port_on = rctl_r[RC_PORT_ENABLE] && async_mode;
	wire detecting = ab_r != AB_OFF;
	wire [7:0] wbyte = pwdata_i[7:0];

	wire [7:0] tc_view = {tctl_r[7:2], !shifter_busy_r, tctl_r[0]};
	wire [7:0] rc_view = {rctl_r[7:3], framing_r, overrun_r, rx_ninth_r};
	wire [7:0] bc_view = {rate_count_overflow_r, rxs_r == RX_IDLE, 2'b00,
		wide_r, 1'b0, wake_r, auto_rate_enable_r};
	wire [7:0] fl_view = {6'h00, !txbuf_full_r, receive_flag_r};
	wire [7:0] rd_mux = hit_tc ? tc_view : hit_rc ? rc_view :
		hit_bc ? bc_view : hit_lo ? rif.divider[7:0] :
		hit_hi ? rif.divider[15:8] : hit_rb ? rxbuf_r :
		hit_fl ? fl_view : 8'h00;

	// read data captured in the setup phase, held for the access phase
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rdata_r <= 32'h00000000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			rdata_r <= {24'h000000, rd_mux};
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic [2:0] edge_r;
	wire ab_done = (ab_r == AB_COUNT) && rx_rise && (edge_r == DETECT_LAST_EDGE);

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			tctl_r <= RST_TRANSMIT_CONTROL;
			rctl_r <= RST_RECEIVE_CONTROL;
			wide_r <= RST_RATE_CONTROL[BC_WIDE_DIVIDER];
			wake_r <= RST_RATE_CONTROL[BC_WAKE_ON_BREAK];
		end else if (wr) begin
			if (hit_tc) begin
				tctl_r <= {wbyte[7:2], 1'b0, wbyte[0]};
			end
			if (hit_rc) begin
				rctl_r <= {wbyte[7:3], 3'b000};
			end
			if (hit_bc) begin
				wide_r <= wbyte[BC_WIDE_DIVIDER];
				wake_r <= wbyte[BC_WAKE_ON_BREAK];
			end
		end
	end

	// software write of the enable outranks the self-clear
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			auto_rate_enable_r <= RST_RATE_CONTROL[BC_AUTO_RATE];
		end else if (wr && hit_bc) begin
			auto_rate_enable_r <= wbyte[BC_AUTO_RATE];
		end else if (ab_done) begin
			auto_rate_enable_r <= 1'b0;
		end
	end

	// hardware rollover wins over a software clear
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rate_count_overflow_r <= RST_RATE_CONTROL[BC_OVERFLOW];
		end else if (rif.det_wrap) begin
			rate_count_overflow_r <= 1'b1;
		end else if (wr && hit_bc) begin
			rate_count_overflow_r <= wbyte[BC_OVERFLOW];
		end
	end

	// ------------------------------------------------------------
	// rate detection sequencer
	// ------------------------------------------------------------
	detect_state_e ab_nxt;

	always_comb begin
		ab_nxt = ab_r;
		case (ab_r)
			AB_OFF: begin
				if (auto_rate_enable_r && async_mode) begin
					ab_nxt = wake_r ? AB_BREAK_LOW : AB_START;
				end
			end
			AB_BREAK_LOW: begin
				if (rx_fall) begin
					ab_nxt = AB_BREAK_HIGH;
				end
			end
			AB_BREAK_HIGH: begin
				if (rx_rise) begin
					ab_nxt = AB_START;
				end
			end
			AB_START: begin
				if (rx_fall) begin
					ab_nxt = AB_FIRST;
				end
			end
			AB_FIRST: begin
				if (rx_rise) begin
					ab_nxt = AB_COUNT;
				end
			end
			AB_COUNT: begin
				// a rollover does not end the run
				if (ab_done) begin
					ab_nxt = AB_OFF;
				end
			end
			default: begin
				ab_nxt = AB_OFF;
			end
		endcase
		if (!auto_rate_enable_r || !async_mode) begin
			ab_nxt = AB_OFF;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			ab_r <= AB_OFF;
			edge_r <= 3'h0;
		end else begin
			ab_r <= ab_nxt;
			if (ab_r == AB_FIRST) begin
				edge_r <= 3'h1;
			end else if (ab_r == AB_COUNT && rx_rise) begin
				edge_r <= 3'(edge_r + 3'h1);
			end
		end
	end

	// calibration assumes the 55h pattern: five rising edges per byte
	assign rif.det_clear = (ab_r == AB_OFF) && (ab_nxt != AB_OFF);
	assign rif.det_run = ab_r == AB_COUNT;
	assign rif.wide = wide_r;
	assign rif.high = tctl_r[TC_HIGH_RATE];
	assign rif.wr_low = wr && hit_lo;
	assign rif.wr_high = wr && hit_hi;
	assign rif.wdata = wbyte;

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	logic [3:0] rx_cnt_r;
	logic [8:0] rx_shift_r;
	wire [3:0] rx_bits = rctl_r[RC_NINE_BIT] ? BITS_NINE : BITS_EIGHT;
	wire rx_go = port_on && rctl_r[RC_RX_ENABLE] && !detecting;
	assign rif.rx_restart = (rxs_r == RX_IDLE) && rx_go && rx_fall;
	wire rx_stop_tick = (rxs_r == RX_STOP) && rif.rx_tick && rx_go;
	wire rb_read = rd && hit_rb;

	always_ff @(posedge mclk_i) begin
		if (!rstn_i || !rx_go) begin
			rxs_r <= RX_IDLE;
			rx_cnt_r <= 4'h0;
			rx_shift_r <= 9'h000;
		end else begin
			case (rxs_r)
				RX_IDLE: begin
					if (rif.rx_restart) begin
						rxs_r <= RX_START;
					end
				end
				RX_START: begin
					if (rif.rx_tick) begin
						rxs_r <= rx_sync_r ? RX_IDLE : RX_DATA;
						rx_cnt_r <= 4'h0;
					end
				end
				RX_DATA: begin
					if (rif.rx_tick) begin
						// lsb arrives first, shift right from the top
						rx_shift_r <= {rx_sync_r, rx_shift_r[8:1]};
						rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
						if (rx_cnt_r == 4'(rx_bits - 4'h1)) begin
							rxs_r <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rif.rx_tick) begin
						rxs_r <= RX_IDLE;
					end
				end
				default: begin
					rxs_r <= RX_IDLE;
				end
			endcase
		end
	end

	// ninth bit passed through untouched, no parity check
	wire [8:0] rx_word = rctl_r[RC_NINE_BIT] ? rx_shift_r :
		{1'b0, rx_shift_r[8:1]};

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			rxbuf_r <= 8'h00;
			rx_ninth_r <= 1'b0;
			framing_r <= 1'b0;
			overrun_r <= 1'b0;
			receive_flag_r <= 1'b0;
		end else begin
			if (rx_stop_tick && receive_flag_r && !rb_read) begin
				overrun_r <= 1'b1;
			end else if (!rctl_r[RC_RX_ENABLE]) begin
				overrun_r <= 1'b0;
			end
			if (rx_stop_tick && (!receive_flag_r || rb_read)) begin
				rxbuf_r <= rx_word[7:0];
				rx_ninth_r <= rx_word[8];
				framing_r <= !rx_sync_r;
			end
			// a new arrival beats a read in the same cycle
			if (ab_done || rx_stop_tick) begin
				receive_flag_r <= 1'b1;
			end else if (rb_read) begin
				receive_flag_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	logic [10:0] tx_shift_r;
	logic [3:0] tx_left_r;
	wire tx_on = port_on && tctl_r[TC_TX_ENABLE];
	wire [3:0] tx_len = tctl_r[TC_NINE_BIT] ? 4'hB : 4'hA;
	// buffer writes are dropped while the auto-rate enable bit is set
	wire tb_write = wr && hit_tb && !auto_rate_enable_r;
	wire tx_load = tx_on && rif.tx_tick && !shifter_busy_r && txbuf_full_r;

	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			txbuf_r <= 9'h000;
			txbuf_full_r <= 1'b0;
		end else if (tb_write) begin
			txbuf_r <= {tctl_r[TC_NINTH_DATA], wbyte};
			txbuf_full_r <= 1'b1;
		end else if (tx_load || !tx_on) begin
			txbuf_full_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rstn_i || !tx_on) begin
			tx_shift_r <= 11'h7FF;
			tx_left_r <= 4'h0;
			shifter_busy_r <= 1'b0;
			serial_output_pin_o <= 1'b1;
		end else if (tx_load) begin
			tx_shift_r <= tctl_r[TC_NINE_BIT] ? {1'b1, txbuf_r, 1'b0} :
				{2'b11, txbuf_r[7:0], 1'b0};
			tx_left_r <= tx_len;
			shifter_busy_r <= 1'b1;
		end else if (rif.tx_tick && shifter_busy_r) begin
			serial_output_pin_o <= tx_shift_r[0];
			tx_shift_r <= {1'b1, tx_shift_r[10:1]};
			tx_left_r <= 4'(tx_left_r - 4'h1);
			shifter_busy_r <= tx_left_r != 4'h1;
		end
	end

endmodule

// ---- src/uart_pkg.sv ----
package uart_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_TRANSMIT_CONTROL = 8'h00;
	localparam logic [7:0] OFS_RECEIVE_CONTROL = 8'h04;
	localparam logic [7:0] OFS_RATE_CONTROL = 8'h08;
	localparam logic [7:0] OFS_DIVIDER_LOW_BYTE = 8'h0C;
	localparam logic [7:0] OFS_DIVIDER_HIGH_BYTE = 8'h10;
	localparam logic [7:0] OFS_TRANSMIT_BUFFER = 8'h14;
	localparam logic [7:0] OFS_RECEIVE_BUFFER = 8'h18;
	localparam logic [7:0] OFS_FLAGS = 8'h1C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int TC_NINE_BIT = 6;
	localparam int TC_TX_ENABLE = 5;
	localparam int TC_CLOCKED_MODE = 4;
	localparam int TC_HIGH_RATE = 2;
	localparam int TC_SHIFTER_EMPTY = 1;
	localparam int TC_NINTH_DATA = 0;
	localparam int RC_PORT_ENABLE = 7;
	localparam int RC_NINE_BIT = 6;
	localparam int RC_RX_ENABLE = 4;
	localparam int RC_FRAMING_ERROR = 2;
	localparam int RC_OVERRUN_ERROR = 1;
	localparam int RC_NINTH_DATA = 0;
	localparam int BC_OVERFLOW = 7;
	localparam int BC_RX_IDLE = 6;
	localparam int BC_WIDE_DIVIDER = 3;
	localparam int BC_WAKE_ON_BREAK = 1;
	localparam int BC_AUTO_RATE = 0;
	localparam int FL_RECEIVE_FLAG = 0;
	localparam int FL_TX_BUFFER_EMPTY = 1;

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] RST_TRANSMIT_CONTROL = 8'h00;
	localparam logic [7:0] RST_RECEIVE_CONTROL = 8'h00;
	localparam logic [7:0] RST_RATE_CONTROL = 8'h00;
	localparam logic [15:0] RST_DIVIDER = 16'h0000;
	localparam logic [9:0] PRE_X64 = 10'h040;
	localparam logic [9:0] PRE_X16 = 10'h010;
	localparam logic [9:0] PRE_X4 = 10'h004;
	localparam int DETECT_SLOWDOWN_SHIFT = 3;
	localparam logic [2:0] DETECT_LAST_EDGE = 3'h4;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;

	// cycles of the oscillator per rate-generator step, minus one
	function automatic logic [8:0] prescale_limit(input logic wide,
			input logic high, input logic detect);
		logic [9:0] k;
		k = (wide & high) ? PRE_X4 : ((wide | high) ? PRE_X16 : PRE_X64);
		if (detect) begin
			k = k << DETECT_SLOWDOWN_SHIFT;
		end
		prescale_limit = 9'(k - 10'h001);
	endfunction

endpackage
